// ==== common/sms_pkg.sv ====
package sms_pkg;

  // Stop mode selection codes
  localparam logic [2:0] SMS_SEL_NORMAL = 3'h0;
  localparam logic [2:0] SMS_SEL_RSVD1  = 3'h1;
  localparam logic [2:0] SMS_SEL_LOWPWR = 3'h2;
  localparam logic [2:0] SMS_SEL_LEAK   = 3'h4;
  localparam logic [2:0] SMS_SEL_RESET  = 3'h0;
  localparam logic [2:0] SMS_SUB_NONE   = 3'h0;

  // Partial stop option codes
  localparam logic [1:0] SMS_PSTOP_NONE   = 2'h0;
  localparam logic [1:0] SMS_PSTOP_BUS    = 2'h1;
  localparam logic [1:0] SMS_PSTOP_SYS    = 2'h2;

  // Mode protection bit positions
  localparam int SMS_PROT_LOWPWR_BIT = 0;
  localparam int SMS_PROT_VLLS_BIT = 1;
  localparam logic [1:0] SMS_PROT_RESET = 2'h0;

  typedef enum logic [1:0] {
    SMS_ST_IDLE  = 2'b00,
    SMS_ST_ENTER = 2'b01,
    SMS_ST_STOP  = 2'b11
  } sms_state_t;

  typedef enum logic [2:0] {
    SMS_MODE_NONE  = 3'h0,
    SMS_MODE_STOP  = 3'h1,
    SMS_MODE_PBUS  = 3'h2,
    SMS_MODE_PSYS  = 3'h3,
    SMS_MODE_LOWPWR = 3'h4,
    SMS_MODE_VLLS  = 3'h5
  } sms_mode_t;

  typedef struct packed {
    logic sys_gate;
    logic bus_gate;
  } sms_gate_t;

endpackage

// ==== rtl/sms_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sms_sync
  import sms_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic [2:0] sh_q;
  logic       q_q;

  // Change counts only once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_q <= 3'h0;
      q_q  <= 1'b0;
    end else begin
      sh_q <= {sh_q[1:0], d_in};
      if (sh_q[2] == sh_q[1]) begin
        q_q <= sh_q[2];
      end
    end
  end

  assign q_out = q_q;
endmodule // sms_sync
`default_nettype wire

// ==== rtl/sms_stop_mode_select_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module sms_stop_mode_select_control
  import sms_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       stop_mode_wr_in,
  input  wire logic [2:0] stop_mode_wdata_in,
  input  wire logic       prot_wr_in,
  input  wire logic [1:0] prot_wdata_in,
  input  wire logic [2:0] leakage_submode_select_in,
  input  wire logic [1:0] partial_stop_option_in,
  input  wire logic       sleep_req_in,
  input  wire logic       abort_in,
  input  wire logic       wake_in,
  output logic [2:0]      stop_mode_select_out,
  output logic [1:0]      mode_protection_out,
  output logic            stop_aborted_flag_out,
  output logic            in_stop_out,
  output logic [2:0]      entered_mode_out,
  output logic [2:0]      leakage_submode_out,
  output logic            sys_clk_gate_out,
  output logic            bus_clk_gate_out
);
  logic       rst_n_q1;
  logic       rst_n_q2;
  logic       abort_s;
  logic       wake_s;
  logic [2:0] sel_q;
  logic [1:0] prot_q;
  logic       prot_written_q;
  logic       aborted_q;
  sms_state_t state_q;
  sms_mode_t  mode_q;
  sms_mode_t  mode_d;
  logic [2:0] submode_q;
  sms_gate_t  gate_q;
  sms_gate_t  gate_d;
  logic       in_stop_q;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_n_q1 <= 1'b0;
      rst_n_q2 <= 1'b0;
    end else begin
      rst_n_q1 <= 1'b1;
      rst_n_q2 <= rst_n_q1;
    end
  end

  // Abort and wake arrive from other clock domains
  sms_sync u_sync_abort (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q2),
    .d_in     (abort_in),
    .q_out    (abort_s)
  );

  sms_sync u_sync_wake (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q2),
    .d_in     (wake_in),
    .q_out    (wake_s)
  );

  // Protection is write-once after reset
  always_ff @(posedge clk_in or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      prot_q         <= SMS_PROT_RESET;
      prot_written_q <= 1'b0;
    end else if (prot_wr_in && !prot_written_q) begin
      prot_q         <= prot_wdata_in;
      prot_written_q <= 1'b1;
    end
  end

  // Mode select field; the first protection write after reset wins over a same-cycle write
  always_ff @(posedge clk_in or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      sel_q <= SMS_SEL_RESET;
    end else if (prot_wr_in && !prot_written_q) begin
      sel_q <= SMS_SEL_RESET;
    end else if (stop_mode_wr_in) begin
      sel_q <= stop_mode_wdata_in;
    end
  end

  // Decode of the requested mode
  always_comb begin
    mode_d = SMS_MODE_NONE;
    unique case (sel_q)
      SMS_SEL_NORMAL: begin
        unique case (partial_stop_option_in)
          SMS_PSTOP_BUS: mode_d = SMS_MODE_PBUS;
          SMS_PSTOP_SYS: mode_d = SMS_MODE_PSYS;
          default:       mode_d = SMS_MODE_STOP;
        endcase
      end
      SMS_SEL_LOWPWR: begin
        if (prot_q[SMS_PROT_LOWPWR_BIT]) begin
          mode_d = SMS_MODE_LOWPWR;
        end
      end
      SMS_SEL_LEAK: begin
        if (prot_q[SMS_PROT_VLLS_BIT]) begin
          mode_d = SMS_MODE_VLLS;
        end
      end
      default: mode_d = SMS_MODE_NONE;
    endcase
  end

  // Clock gating per entered mode
  always_comb begin
    gate_d = '{sys_gate: 1'b1, bus_gate: 1'b1};
    if (mode_d == SMS_MODE_PSYS) begin
      gate_d.bus_gate = 1'b0;
    end
  end

  // Entry sequencer
  always_ff @(posedge clk_in or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      state_q <= SMS_ST_IDLE;
    end else begin
      unique case (state_q)
        SMS_ST_IDLE: begin
          if (sleep_req_in && mode_d != SMS_MODE_NONE) begin
            state_q <= SMS_ST_ENTER;
          end
        end
        SMS_ST_ENTER: begin
          state_q <= abort_s ? SMS_ST_IDLE : SMS_ST_STOP;
        end
        SMS_ST_STOP: begin
          if (wake_s) begin
            state_q <= SMS_ST_IDLE;
          end
        end
        default: state_q <= SMS_ST_IDLE;
      endcase
    end
  end

  // Aborted flag; abort at entry sets it, new entry clears it
  always_ff @(posedge clk_in or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      aborted_q <= 1'b0;
    end else if (state_q == SMS_ST_ENTER && abort_s) begin
      aborted_q <= 1'b1;
    end else if (state_q == SMS_ST_IDLE && sleep_req_in &&
                 mode_d != SMS_MODE_NONE) begin
      aborted_q <= 1'b0;
    end
  end

  // Mode and gating latched at entry so writes during stop do not disturb
  always_ff @(posedge clk_in or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      mode_q    <= SMS_MODE_NONE;
      submode_q <= SMS_SUB_NONE;
      gate_q    <= '0;
      in_stop_q <= 1'b0;
    end else if (state_q == SMS_ST_ENTER && !abort_s) begin
      mode_q    <= mode_d;
      submode_q <= (mode_d == SMS_MODE_VLLS) ?
                   leakage_submode_select_in : SMS_SUB_NONE;
      gate_q    <= gate_d;
      in_stop_q <= 1'b1;
    end else if (state_q != SMS_ST_STOP) begin
      mode_q    <= SMS_MODE_NONE;
      submode_q <= SMS_SUB_NONE;
      gate_q    <= '0;
      in_stop_q <= 1'b0;
    end else if (wake_s) begin
      mode_q    <= SMS_MODE_NONE;
      submode_q <= SMS_SUB_NONE;
      gate_q    <= '0;
      in_stop_q <= 1'b0;
    end
  end

  assign stop_mode_select_out  = sel_q;
  assign mode_protection_out   = prot_q;
  assign stop_aborted_flag_out = aborted_q;
  assign in_stop_out           = in_stop_q;
  assign entered_mode_out      = mode_q;
  assign leakage_submode_out   = submode_q;
  assign sys_clk_gate_out      = gate_q.sys_gate;
  assign bus_clk_gate_out      = gate_q.bus_gate;

  // Assertions
  property p_prot_clears;
    @(posedge clk_in) disable iff (!rst_n_q2)
      (prot_wr_in && !prot_written_q) |=> sel_q == SMS_SEL_RESET;
  endproperty
  a_prot_clears: assert property (p_prot_clears)
    else $error("select not cleared by protection write");

  property p_last_write;
    @(posedge clk_in) disable iff (!rst_n_q2)
      (stop_mode_wr_in && !(prot_wr_in && !prot_written_q))
      |=> sel_q == $past(stop_mode_wdata_in);
  endproperty
  a_last_write: assert property (p_last_write)
    else $error("select did not take written value");

  property p_vlls_sub;
    @(posedge clk_in) disable iff (!rst_n_q2)
      $rose(in_stop_q) && mode_q == SMS_MODE_VLLS
      |-> submode_q == $past(leakage_submode_select_in);
  endproperty
  a_vlls_sub: assert property (p_vlls_sub)
    else $error("wrong leakage submode");

  property p_pstop_bus;
    @(posedge clk_in) disable iff (!rst_n_q2)
      in_stop_q && mode_q == SMS_MODE_PBUS
      |-> gate_q.sys_gate && gate_q.bus_gate;
  endproperty
  a_pstop_bus: assert property (p_pstop_bus)
    else $error("bus clock not gated in bus-gated partial stop");

  property p_pstop_sys;
    @(posedge clk_in) disable iff (!rst_n_q2)
      in_stop_q && mode_q == SMS_MODE_PSYS
      |-> gate_q.sys_gate && !gate_q.bus_gate;
  endproperty
  a_pstop_sys: assert property (p_pstop_sys)
    else $error("wrong gating in sys-gated partial stop");

  property p_rsvd;
    @(posedge clk_in) disable iff (!rst_n_q2)
      state_q == SMS_ST_IDLE && sel_q == SMS_SEL_RSVD1
      |=> state_q == SMS_ST_IDLE;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved code started entry");

  property p_normal_stop;
    @(posedge clk_in) disable iff (!rst_n_q2)
      state_q == SMS_ST_IDLE && sleep_req_in &&
      sel_q == SMS_SEL_NORMAL |=> state_q == SMS_ST_ENTER;
  endproperty
  a_normal_stop: assert property (p_normal_stop)
    else $error("normal stop not entered");

  property p_lowpwr_code;
    @(posedge clk_in) disable iff (!rst_n_q2)
      $rose(in_stop_q) && mode_q == SMS_MODE_LOWPWR
      |-> $past(sel_q) == SMS_SEL_LOWPWR;
  endproperty
  a_lowpwr_code: assert property (p_lowpwr_code)
    else $error("very-low-power stop from wrong code");

  property p_abort;
    @(posedge clk_in) disable iff (!rst_n_q2)
      state_q == SMS_ST_ENTER && abort_s
      |=> aborted_q && !in_stop_q && state_q == SMS_ST_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not flagged");

  property p_prot;
    @(posedge clk_in) disable iff (!rst_n_q2)
      $rose(in_stop_q)
      |-> (mode_q != SMS_MODE_VLLS || prot_q[SMS_PROT_VLLS_BIT]) &&
          (mode_q != SMS_MODE_LOWPWR || prot_q[SMS_PROT_LOWPWR_BIT]);
  endproperty
  a_prot: assert property (p_prot)
    else $error("entered unpermitted mode");

  c_stop: cover property (@(posedge clk_in) $rose(in_stop_q));
  c_abort: cover property (@(posedge clk_in) $rose(aborted_q));
  c_vlls: cover property (@(posedge clk_in)
    in_stop_q && mode_q == SMS_MODE_VLLS);
endmodule // sms_stop_mode_select_control
`default_nettype wire

// ==== tb/sms_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sms_core_model (
  input  wire logic clk_in,
  output logic      sleep_req_out,
  output logic      abort_out,
  output logic      wake_out
);
  initial begin
    sleep_req_out = 1'b0;
    abort_out     = 1'b0;
    wake_out      = 1'b0;
  end
  // One-cycle request, as the core gives
  task automatic sleep_now();
    @(posedge clk_in) sleep_req_out <= 1'b1;
    @(posedge clk_in) sleep_req_out <= 1'b0;
  endtask
  // Levels; the block resyncs them, so hold them long
  task automatic set_abort(input logic v);
    @(posedge clk_in) abort_out <= v;
  endtask
  task automatic set_wake(input logic v);
    @(posedge clk_in) wake_out <= v;
  endtask
endmodule // sms_core_model
`default_nettype wire

// ==== tb/sms_stop_mode_select_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sms_stop_mode_select_control_tb_top;
  import sms_pkg::*;
  logic       clk_in = 0, arst_n_in = 0, mwr = 0, pwr = 0;
  logic [2:0] mdat = 0, lsub = 0, sel, mode, sub;
  logic [1:0] pdat = 0, popt = 0, prot;
  logic       flag, stp, sg, bg;
  wire logic  sreq, abrt, wk;
  int         n_fail = 0, checked = 0;
  logic [2:0] md[4] = '{3'h1, 3'h2, 3'h3, 3'h1};
  logic [1:0] gt[4] = '{2'h3, 2'h3, 2'h2, 2'h3};
  logic [2:0] rsv[5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  initial forever #4 clk_in = ~clk_in;
  sms_core_model core (.clk_in(clk_in), .sleep_req_out(sreq),
    .abort_out(abrt), .wake_out(wk));
  sms_stop_mode_select_control uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .stop_mode_wr_in(mwr), .stop_mode_wdata_in(mdat), .prot_wr_in(pwr),
    .prot_wdata_in(pdat), .leakage_submode_select_in(lsub),
    .partial_stop_option_in(popt), .sleep_req_in(sreq), .abort_in(abrt),
    .wake_in(wk), .stop_mode_select_out(sel), .mode_protection_out(prot),
    .stop_aborted_flag_out(flag), .in_stop_out(stp),
    .entered_mode_out(mode), .leakage_submode_out(sub),
    .sys_clk_gate_out(sg), .bus_clk_gate_out(bg));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_sel(input logic [2:0] v);
    @(posedge clk_in) begin mwr <= 1'b1; mdat <= v; end
    @(posedge clk_in) mwr <= 1'b0;
  endtask
  task automatic wr_prot(input logic [1:0] v);
    @(posedge clk_in) begin pwr <= 1'b1; pdat <= v; end
    @(posedge clk_in) pwr <= 1'b0;
    @(negedge clk_in);
  endtask
  // Bounded wait; sampled on falling edge, clear of the update edge
  task automatic wait_stop(input logic v);
    for (int i = 0; i < 12 && stp !== v; i++) @(negedge clk_in);
    if (stp !== v) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Expected mode 0 means the request must be ignored
  task automatic enter(input logic [2:0] m, input logic [1:0] g);
    core.sleep_now();
    if (m == 3'h0) begin
      repeat (8) @(negedge clk_in);
      chk(8'(stp), 8'h00);
    end else begin
      wait_stop(1'b1);
      chk(8'(mode), 8'(m));
      chk(8'({sg, bg}), 8'(g));
      chk(8'(sub), (m == 3'h5) ? 8'(lsub) : 8'h00);
      core.set_wake(1'b1);
      wait_stop(1'b0);
      core.set_wake(1'b0);
      repeat (5) @(posedge clk_in);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk(8'(sel), 8'h00);
    chk(8'(prot), 8'h00);
    chk(8'({flag, stp, mode, sg, bg}), 8'h00);
    chk(8'(sub), 8'h00);
    $display("test reset done");
    wr_sel(SMS_SEL_NORMAL);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in) popt <= 2'(i);
      enter(md[i], gt[i]);
    end
    @(posedge clk_in) popt <= 2'h0;
    $display("test partial done");
    wr_sel(SMS_SEL_LOWPWR);
    enter(3'h0, 2'h0);
    wr_sel(SMS_SEL_LEAK);
    enter(3'h0, 2'h0);
    wr_prot(2'h3);
    chk(8'(sel), 8'h00);
    chk(8'(prot), 8'h03);
    wr_prot(2'h0);
    chk(8'(prot), 8'h03);
    $display("test protection done");
    wr_sel(SMS_SEL_LOWPWR);
    @(negedge clk_in) chk(8'(sel), 8'h02);
    enter(3'h4, 2'h3);
    @(posedge clk_in) lsub <= 3'h5;
    wr_sel(SMS_SEL_LEAK);
    enter(3'h5, 2'h3);
    for (int i = 0; i < 5; i++) begin
      wr_sel(rsv[i]);
      enter(3'h0, 2'h0);
    end
    $display("test modes done");
    wr_sel(SMS_SEL_NORMAL);
    core.set_abort(1'b1);
    repeat (4) @(posedge clk_in);
    core.sleep_now();
    repeat (8) @(negedge clk_in);
    chk(8'(flag), 8'h01);
    chk(8'(stp), 8'h00);
    core.set_abort(1'b0);
    repeat (5) @(posedge clk_in);
    enter(3'h1, 2'h3);
    chk(8'(flag), 8'h00);
    $display("test abort done");
    print_verdict();
  end
endmodule // sms_stop_mode_select_control_tb_top
`default_nettype wire
